/* File: hdl/rcf_pkg.sv */
package rcf_pkg;

    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 8;
    localparam int          WORD_W       = 40;
    localparam int          CMD_W        = 20;
    localparam int          NUM_REGS     = 8;

    // Register map, byte addresses
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;
    localparam logic [7:0]  OFF_CMD      = 8'h08;
    localparam logic [7:0]  OFF_REG_BASE = 8'h20;
    localparam logic [7:0]  OFF_REG_LAST = 8'h5C;
    localparam logic [7:0]  REG_STRIDE   = 8'h08;
    localparam logic [7:0]  OFF_GUARD    = 8'h04;

    // Status word field positions
    localparam int          STAT_FLAGS_LSB = 0;
    localparam int          STAT_BUSY_BIT  = 8;

    // Reset values
    localparam logic [3:0]  CTRL_RST     = 4'h0;
    localparam logic [39:0] REG_RST      = 40'h00_0000_0000;

    // Datapath constants
    localparam logic [39:0] ROUND_CONST  = 40'h00_0000_8000;
    localparam logic [39:0] ROUND_MASK   = 40'hFF_FFFF_0000;
    localparam logic [39:0] SAT_POS      = 40'h00_7FFF_FFFF;
    localparam logic [39:0] SAT_NEG      = 40'hFF_8000_0000;
    localparam int          MSB_BIAS     = 8;

    typedef enum logic [3:0] {
        OP_ROUND, OP_MSB, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
        OP_ASHIFT, OP_LSHIFT
    } rcf_op_type;

    typedef enum logic [2:0] {
        CS_CARRY, CS_NEG, CS_ZERO, CS_OVF, CS_GT, CS_GE, CS_RSV6, CS_RSV7
    } rcf_cs_type;

    typedef enum logic [2:0] {
        R_X0, R_X1, R_Y0, R_Y1, R_M0, R_M1, R_A0, R_A1
    } rcf_reg_type;

    typedef struct packed {
        logic cond_flag;
        logic sign_flag;
        logic zero_flag;
        logic ovf_flag;
        logic gt_flag;
    } rcf_flags_type;

    typedef struct packed {
        logic       sat_enable;
        rcf_cs_type cond_select_field;
    } rcf_ctrl_type;

    typedef struct packed {
        logic        cond_exec;
        logic [5:0]  shamt;
        rcf_reg_type dest_operand;
        rcf_reg_type src_b;
        rcf_reg_type src_a;
        rcf_op_type  op;
    } rcf_cmd_type;

endpackage

/* File: hdl/rcf_round_flags.sv */
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rcf_round_flags (
    input  wire logic                       REF_CLK,
    input  wire logic                       RESETN,
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [rcf_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [rcf_pkg::DATA_W-1:0] PWDATA,
    output logic      [rcf_pkg::DATA_W-1:0] PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    output rcf_pkg::rcf_flags_type          FLAGS
);
    import rcf_pkg::*;

    logic [39:0]   regs_reg [NUM_REGS];
    rcf_ctrl_type  ctrl_reg;
    rcf_flags_type flags_reg;
    rcf_cmd_type   cmd_reg;
    logic          exec_reg;
    logic [39:0]   opa_reg;
    logic [39:0]   opb_reg;
    logic [31:0]   prdata_reg;

    logic          setup_phase;
    logic          access_wr;
    logic          addr_ok;
    logic          reg_hit;
    logic [2:0]    reg_idx;
    logic          guard_sel;
    logic [31:0]   rd_next;

    logic [40:0]   sum41;
    logic [39:0]   raw_res;
    logic [39:0]   res;
    logic          carry;
    logic          v40;
    logic          shout;
    logic          is_arith;
    logic          is_shift;
    logic          is_logic;
    logic          is_msb;
    logic          can_sat;
    logic          ovf_raw;
    logic          ovf_out;
    logic          corr_sign;
    logic          zero_res;
    logic          legal_op;
    rcf_flags_type flags_next;
    logic          do_write;
    logic          cond_cmd;

    function automatic logic [39:0] sext32(input logic [31:0] v);
        sext32 = {{8{v[31]}}, v};
    endfunction

    function automatic logic is_acc(input rcf_reg_type r);
        is_acc = (r == R_A0) || (r == R_A1);
    endfunction

    // Only accumulators hold real guard bits; others are sign extended
    function automatic logic [39:0] store_val(input rcf_reg_type r,
                                              input logic [39:0] v);
        store_val = is_acc(r) ? v : sext32(v[31:0]);
    endfunction

    // Redundant sign bits below bit 39, biased to the 32-bit word
    function automatic logic [39:0] msb_count(input logic [39:0] v);
        int   n;
        logic run;
        n   = 0;
        run = 1'b1;
        for (int i = 38; i >= 0; i--) begin
            if (run && (v[i] == v[39])) begin
                n = n + 1;
            end else begin
                run = 1'b0;
            end
        end
        n = n - MSB_BIAS;
        msb_count = {{24{n[31]}}, n[15:0]};
    endfunction

    // APB decode; registers answer with no wait state
    assign setup_phase = PSEL && !PENABLE;
    assign access_wr   = PSEL && PENABLE && PWRITE;
    assign reg_hit     = (PADDR >= OFF_REG_BASE) && (PADDR <= OFF_REG_LAST);
    assign reg_idx     = 3'((PADDR - OFF_REG_BASE) >> 3);
    assign guard_sel   = PADDR[2];
    assign addr_ok     = (PADDR[1:0] == 2'b00) &&
                         ((PADDR == OFF_CTRL) || (PADDR == OFF_STATUS) ||
                          (PADDR == OFF_CMD) || reg_hit);
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL && PENABLE && !addr_ok;
    assign PRDATA      = prdata_reg;
    assign FLAGS       = flags_reg;

    always_comb begin
        rd_next = '0;
        if (reg_hit) begin
            rd_next = guard_sel ? {24'h000000, regs_reg[reg_idx][39:32]}
                                : regs_reg[reg_idx][31:0];
        end else if (PADDR == OFF_CTRL) begin
            rd_next = {28'h0000000, ctrl_reg};
        end else if (PADDR == OFF_STATUS) begin
            rd_next[STAT_FLAGS_LSB +: 5] = flags_reg;
            rd_next[STAT_BUSY_BIT]       = exec_reg;
        end
    end

    // Read data is captured in the setup cycle so it stands in access
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_reg <= '0;
        end else if (setup_phase && !PWRITE) begin
            prdata_reg <= rd_next;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_reg <= rcf_ctrl_type'(CTRL_RST);
        end else if (access_wr && (PADDR == OFF_CTRL)) begin
            ctrl_reg <= rcf_ctrl_type'(PWDATA[3:0]);
        end
    end

    // Command stage: operands are latched with the command
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            exec_reg <= 1'b0;
            cmd_reg  <= '0;
            opa_reg  <= '0;
            opb_reg  <= '0;
        end else if (access_wr && (PADDR == OFF_CMD)) begin
            exec_reg <= 1'b1;
            cmd_reg  <= rcf_cmd_type'(PWDATA[CMD_W-1:0]);
            opa_reg  <= regs_reg[PWDATA[6:4]];
            opb_reg  <= regs_reg[PWDATA[9:7]];
        end else begin
            exec_reg <= 1'b0;
        end
    end

    // Execution stage datapath
    always_comb begin
        sum41    = '0;
        raw_res  = '0;
        carry    = 1'b0;
        v40      = 1'b0;
        shout    = 1'b0;
        is_arith = 1'b0;
        is_shift = 1'b0;
        is_logic = 1'b0;
        is_msb   = 1'b0;
        can_sat  = 1'b0;
        legal_op = 1'b1;
        case (cmd_reg.op)
            OP_ROUND: begin
                sum41    = {1'b0, opa_reg} + {1'b0, ROUND_CONST};
                raw_res  = sum41[39:0] & ROUND_MASK;
                carry    = sum41[40];
                v40      = !opa_reg[39] && sum41[39];
                is_arith = 1'b1;
                can_sat  = 1'b1;
            end
            OP_ADD: begin
                sum41    = {1'b0, opa_reg} + {1'b0, opb_reg};
                raw_res  = sum41[39:0];
                carry    = sum41[40];
                v40      = (opa_reg[39] == opb_reg[39]) &&
                           (sum41[39] != opa_reg[39]);
                is_arith = 1'b1;
                can_sat  = 1'b1;
            end
            OP_SUB: begin
                sum41    = {1'b0, opa_reg} - {1'b0, opb_reg};
                raw_res  = sum41[39:0];
                carry    = sum41[40];
                v40      = (opa_reg[39] != opb_reg[39]) &&
                           (sum41[39] != opa_reg[39]);
                is_arith = 1'b1;
                can_sat  = 1'b1;
            end
            OP_MSB: begin
                raw_res  = msb_count(opa_reg);
                is_msb   = 1'b1;
            end
            OP_AND: begin
                raw_res  = {8'h00, opa_reg[31:0] & opb_reg[31:0]};
                is_logic = 1'b1;
            end
            OP_OR: begin
                raw_res  = {8'h00, opa_reg[31:0] | opb_reg[31:0]};
                is_logic = 1'b1;
            end
            OP_XOR: begin
                raw_res  = {8'h00, opa_reg[31:0] ^ opb_reg[31:0]};
                is_logic = 1'b1;
            end
            OP_ASHIFT: begin
                is_arith = 1'b1;
                is_shift = 1'b1;
                if (!cmd_reg.shamt[5]) begin
                    raw_res = opa_reg << cmd_reg.shamt[4:0];
                    if (cmd_reg.shamt != 6'h00) begin
                        shout = opa_reg[6'd40 - cmd_reg.shamt];
                    end
                end else begin
                    raw_res = 40'($signed(opa_reg) >>> (6'h00 - cmd_reg.shamt));
                    shout   = opa_reg[6'h3F - cmd_reg.shamt];
                end
            end
            OP_LSHIFT: begin
                is_logic = 1'b1;
                is_shift = 1'b1;
                if (!cmd_reg.shamt[5]) begin
                    raw_res = {8'h00, opa_reg[31:0] << cmd_reg.shamt[4:0]};
                    if (cmd_reg.shamt != 6'h00) begin
                        shout = opa_reg[6'd32 - cmd_reg.shamt];
                    end
                end else begin
                    raw_res = {8'h00,
                               opa_reg[31:0] >> (6'h00 - cmd_reg.shamt)};
                    shout   = opa_reg[6'h3F - cmd_reg.shamt];
                end
            end
            default: begin
                legal_op = 1'b0;
            end
        endcase
    end

    // Overflow is the 32-bit range; corrected sign covers guard overflow
    always_comb begin
        ovf_raw   = is_arith && ((raw_res[39:31] != 9'h000) &&
                                 (raw_res[39:31] != 9'h1FF) || v40);
        corr_sign = v40 ? !raw_res[39] : raw_res[39];
        res       = raw_res;
        ovf_out   = ovf_raw;
        if (ctrl_reg.sat_enable && can_sat && ovf_raw) begin
            res     = corr_sign ? SAT_NEG : SAT_POS;
            ovf_out = 1'b0;
        end
        if (is_msb) begin
            ovf_out = 1'b0;
        end
    end

    assign zero_res = (res == 40'h00_0000_0000);

    // Flag computation for every unconditional operation
    always_comb begin
        flags_next           = flags_reg;
        flags_next.zero_flag = zero_res;
        flags_next.ovf_flag  = ovf_out;
        if (is_logic) begin
            flags_next.sign_flag = res[31];
            flags_next.gt_flag   = !res[31] && !zero_res;
        end else begin
            flags_next.sign_flag = res[39];
            flags_next.gt_flag   = !corr_sign && !zero_res;
        end
        unique case (ctrl_reg.cond_select_field)
            CS_CARRY: begin
                if (is_shift) begin
                    flags_next.cond_flag = shout;
                end else begin
                    flags_next.cond_flag = is_arith && carry;
                end
            end
            CS_NEG: begin
                flags_next.cond_flag = is_logic ? res[31]
                                                : res[39];
            end
            CS_ZERO: begin
                flags_next.cond_flag = zero_res;
            end
            CS_OVF: begin
                flags_next.cond_flag = !is_logic && ovf_out;
            end
            CS_GT: begin
                flags_next.cond_flag = !is_logic && !corr_sign &&
                                       !zero_res;
            end
            CS_GE: begin
                flags_next.cond_flag = !is_logic && !corr_sign;
            end
            CS_RSV6, CS_RSV7: begin
                flags_next.cond_flag = flags_reg.cond_flag;
            end
        endcase
    end

    // Rounding ignores the conditional bit: it always runs
    assign cond_cmd = cmd_reg.cond_exec &&
                      (cmd_reg.op != OP_ROUND);

    // A conditional command runs only when cond_flag is set
    assign do_write = exec_reg && legal_op &&
                      (!cond_cmd || flags_reg.cond_flag);

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            flags_reg <= '0;
        end else if (exec_reg && legal_op && !cond_cmd) begin
            flags_reg <= flags_next;
        end
    end

    // Writeback wins over a bus write; both cannot meet under APB timing
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_reg[i] <= REG_RST;
            end
        end else if (do_write) begin
            regs_reg[cmd_reg.dest_operand] <=
                store_val(cmd_reg.dest_operand, res);
        end else if (access_wr && reg_hit && (PADDR[1:0] == 2'b00)) begin
            if (!guard_sel) begin
                regs_reg[reg_idx] <= store_val(rcf_reg_type'(reg_idx),
                    {regs_reg[reg_idx][39:32], PWDATA});
            end else if (is_acc(rcf_reg_type'(reg_idx))) begin
                regs_reg[reg_idx][39:32] <= PWDATA[7:0];
            end
        end
    end

endmodule

`default_nettype wire

/* File: tb/rcf_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rcf_cpu_model (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata
);
    import rcf_pkg::*;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'h0;
    end

    // One APB transfer; the wait for pready is bounded
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err, output logic tmo);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        tmo = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released bus shows inverted values, so stale data never matches
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

`default_nettype wire

/* File: tb/rcf_round_flags_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module rcf_monitor (
    input wire logic                       REF_CLK,
    input wire logic                       RESETN,
    input wire logic                       PSEL,
    input wire logic                       PENABLE,
    input wire logic                       PWRITE,
    input wire logic [rcf_pkg::ADDR_W-1:0] PADDR,
    input wire logic [rcf_pkg::DATA_W-1:0] PWDATA,
    input wire logic [rcf_pkg::DATA_W-1:0] PRDATA,
    input wire logic                       PREADY,
    input wire logic                       PSLVERR,
    input wire rcf_pkg::rcf_flags_type     FLAGS
);
    import rcf_pkg::*;

    logic [3:0] ctrl_reg;
    logic       wcmd;
    logic       go;
    logic       rnd;
    logic [3:0] op;
    logic [2:0] cs;
    logic [2:0] sgz;

    assign wcmd = PSEL && PENABLE && PWRITE && PREADY && PADDR == OFF_CMD;
    assign go = wcmd && (!PWDATA[19] || PWDATA[3:0] == 4'h0);
    assign op = PWDATA[3:0];
    assign rnd = go && op == 4'h0;
    assign cs = ctrl_reg[2:0];
    assign sgz = {FLAGS.sign_flag, FLAGS.zero_flag, FLAGS.gt_flag};

    // Mode is latched here since only the bus shows it
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_reg <= 4'h0;
        end else if (PSEL && PENABLE && PWRITE && PADDR == OFF_CTRL) begin
            ctrl_reg <= PWDATA[3:0];
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    a_msb_ovf_zero: assert property (
        go && op == 4'h1 |-> ##2 !FLAGS.ovf_flag)
        else $error("ovf set after msb detect");
    a_round_onehot: assert property (
        rnd |-> ##2 $onehot(sgz))
        else $error("sign zero gt not exclusive after round");
    a_neg_mode: assert property (
        rnd && cs == 3'd1 |-> ##2 FLAGS.cond_flag == FLAGS.sign_flag)
        else $error("cond differs from sign");
    a_zero_mode: assert property (
        rnd && cs == 3'd2 |-> ##2 FLAGS.cond_flag == FLAGS.zero_flag)
        else $error("cond differs from zero");
    a_ovf_mode: assert property (
        rnd && cs == 3'd3 |-> ##2 FLAGS.cond_flag == FLAGS.ovf_flag)
        else $error("cond differs from ovf");
    a_gt_mode: assert property (
        rnd && cs == 3'd4 |-> ##2 FLAGS.cond_flag == FLAGS.gt_flag)
        else $error("cond differs from gt");
    a_ge_mode: assert property (
        rnd && cs == 3'd5 |-> ##2 FLAGS.cond_flag != FLAGS.sign_flag)
        else $error("cond not inverse of sign");
    a_cond_hold: assert property (
        wcmd && PWDATA[19] && op != 4'h0 |=> $stable(FLAGS) [*2])
        else $error("flags moved on conditional op");
    a_logic_carry: assert property (
        go && op inside {4'h4, 4'h5, 4'h6} && cs == 3'd0
        |-> ##2 !FLAGS.cond_flag)
        else $error("cond set by logical op");
    a_gt_zero_clr: assert property (
        go && op <= 4'h8 && cs == 3'd4
        |-> ##2 !(FLAGS.cond_flag && FLAGS.zero_flag))
        else $error("cond set on zero result");
endmodule

bind rcf_round_flags rcf_monitor u_mon (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FLAGS(FLAGS)
);

`default_nettype wire

/* File: tb/rcf_round_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("BAD %s exp=%0h got=%0h", nm, e, g); \
    end \
end

module rcf_round_flags_tb_top;
    import rcf_pkg::*;

    logic          REF_CLK = 1'b0;
    logic          RESETN = 1'b0;
    logic          PSEL;
    logic          PENABLE;
    logic          PWRITE;
    logic [7:0]    PADDR;
    logic [31:0]   PWDATA;
    logic [31:0]   PRDATA;
    logic          PREADY;
    logic          PSLVERR;
    rcf_flags_type FLAGS;
    logic [31:0]   rd_q;
    logic          err_q;
    int            n_mismatch = 0;
    int            cmp_count = 0;

    always #20 REF_CLK = ~REF_CLK;

    rcf_round_flags dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .FLAGS(FLAGS));

    rcf_cpu_model u_cpu (.clk(REF_CLK), .pready(PREADY), .pslverr(PSLVERR),
        .prdata(PRDATA), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
        .paddr(PADDR), .pwdata(PWDATA));

    task automatic wrap_up();
        $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        logic tmo;
        u_cpu.xfer(wr, a, d, rd_q, err_q, tmo);
        if (tmo) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // Set mode, launch, then look at flags once the result has landed
    task automatic step(input logic [3:0] ctl, input logic [19:0] cmd,
                        input logic [4:0] flg, input logic [7:0] ra,
                        input logic [31:0] rv);
        bus(1'b1, OFF_CTRL, {28'h0, ctl});
        bus(1'b1, OFF_CMD, {12'h0, cmd});
        @(posedge REF_CLK);
        #1;
        `CK("flags", flg, FLAGS)
        if (ra != 8'h00) begin
            bus(1'b0, ra, 32'h0);
            `CK("dest", rv, rd_q)
        end
    endtask

    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_mismatch++;
        wrap_up();
    end

    // Commands: op[3:0] src_a[6:4] src_b[9:7] dest[12:10] shamt cond[19]
    initial begin
        repeat (20) @(posedge REF_CLK);
        RESETN <= 1'b1;
        @(posedge REF_CLK);
        #1;
        `CK("flags_rst", 5'h00, FLAGS)
        bus(1'b0, OFF_CTRL, 32'h0);
        `CK("ctrl_rst", 32'h0, rd_q)
        bus(1'b0, 8'h10, 32'h0);
        `CK("unmapped_err", 1'b1, err_q)
        `CK("unmapped_data", 32'h0, rd_q)
        bus(1'b1, 8'h20, 32'h12348000);
        bus(1'b1, 8'h28, 32'h7FFF8000);
        bus(1'b1, 8'h30, 32'h00000001);
        bus(1'b1, 8'h38, 32'h80000001);
        bus(1'b1, 8'h3C, 32'h00000000);
        bus(1'b1, 8'h50, 32'hFFFF0000);
        bus(1'b1, 8'h54, 32'h000000FF);
        bus(1'b1, 8'h58, 32'hFFFF8000);
        bus(1'b1, 8'h5C, 32'h000000FF);
        bus(1'b0, 8'h3C, 32'h0);
        `CK("guard_ext", 32'h000000FF, rd_q)
        step(4'h0, 20'h01000, 5'h01, 8'h40, 32'h12350000);
        step(4'h4, 20'h01000, 5'h11, 8'h00, 32'h0);
        step(4'h5, 20'h01000, 5'h11, 8'h00, 32'h0);
        step(4'h0, 20'h017F0, 5'h14, 8'h48, 32'h0);
        step(4'h2, 20'h017F0, 5'h14, 8'h00, 32'h0);
        step(4'h4, 20'h017F0, 5'h04, 8'h00, 32'h0);
        step(4'h5, 20'h017F0, 5'h14, 8'h00, 32'h0);
        step(4'h1, 20'h01760, 5'h18, 8'h4C, 32'h000000FF);
        step(4'h3, 20'h01760, 5'h08, 8'h00, 32'h0);
        step(4'h5, 20'h01760, 5'h08, 8'h00, 32'h0);
        step(4'h3, 20'h01890, 5'h13, 8'h50, 32'h80000000);
        bus(1'b0, 8'h54, 32'h0);
        `CK("guard_ovf", 32'h0, rd_q)
        step(4'hB, 20'h01890, 5'h01, 8'h50, 32'h7FFFFFFF);
        step(4'h3, 20'h01890, 5'h13, 8'h00, 32'h0);
        step(4'h2, 20'h01121, 5'h01, 8'h00, 32'h0);
        step(4'h0, 20'h011B4, 5'h08, 8'h40, 32'h80000001);
        step(4'h1, 20'h011B4, 5'h18, 8'h00, 32'h0);
        step(4'h3, 20'h011B4, 5'h08, 8'h00, 32'h0);
        step(4'h0, 20'h031B8, 5'h11, 8'h40, 32'h00000002);
        step(4'h0, 20'h7F127, 5'h14, 8'h40, 32'h0);
        step(4'h0, 20'h81002, 5'h14, 8'h40, 32'h24690000);
        step(4'h0, 20'h01000, 5'h01, 8'h40, 32'h12350000);
        step(4'h0, 20'h81002, 5'h01, 8'h40, 32'h12350000);
        step(4'h6, 20'h013F0, 5'h04, 8'h00, 32'h0);
        step(4'h0, 20'h81000, 5'h01, 8'h40, 32'h12350000);
        step(4'h0, 20'h010A3, 5'h18, 8'h40, 32'h80008001);
        step(4'h0, 20'h0100F, 5'h18, 8'h40, 32'h80008001);
        step(4'h4, 20'h01105, 5'h01, 8'h40, 32'h12348001);
        bus(1'b0, OFF_STATUS, 32'h0);
        `CK("status", 32'h00000001, rd_q)
        wrap_up();
    end
endmodule

`default_nettype wire
